// [temp_alarm_pkg.sv]
// Constants, register map and carrier types of the temperature alarm block.
// Assumes one system clock; all users import the whole package.
package temp_alarm_pkg;
	// Register indices selected by the register pointer
	localparam logic [7:0] REG_SETUP = 8'h41;
	localparam logic [7:0] REG_WARN_MASK = 8'h42;
	localparam logic [7:0] REG_OT_MASK = 8'h43;
	localparam logic [7:0] REG_HIGH_STAT = 8'h44;
	localparam logic [7:0] REG_OT_STAT = 8'h45;
	localparam logic [7:0] REG_LOW_STAT = 8'h47;
	// Power-on values
	localparam logic [7:0] SETUP_RST = 8'h00;
	localparam logic [7:0] MASK_RST = 8'h00;
	localparam logic [7:0] PTR_RST = 8'h00;
	localparam logic [7:0] STAT_RST = 8'h00;
	// device_setup field positions
	localparam int BIT_STANDBY = 7;
	localparam int BIT_SOFT_RST = 6;
	localparam int BIT_NO_TIMEOUT = 5;
	localparam int BIT_WIDE = 1;
	// Bits that hold state; the soft reset bit never sticks
	localparam logic [7:0] SETUP_KEEP = 8'hA2;
	// Alert response address as it appears on the wire, read bit set
	localparam logic [7:0] ARA_BYTE = 8'h19;
	// Overtemperature hysteresis in degrees
	localparam logic [8:0] OT_HYST = 9'h004;
	// Bus timeout
	localparam int CLK_KHZ = 40000;
	localparam int TIMEOUT_MS = 25;
	localparam int TIMEOUT_CYC = TIMEOUT_MS * CLK_KHZ;
	// Own slave address; the value is arbitrary
	localparam logic [6:0] DEV_ADDR_DEF = 7'h4C;

	// Serial link sequencer states
	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_ADDR = 4'h1,
		ST_ADDR_ACK = 4'h2,
		ST_CMD = 4'h3,
		ST_WDATA = 4'h4,
		ST_RX_ACK = 4'h5,
		ST_TX = 4'h6,
		ST_TX_ACK = 4'h7,
		ST_TX_NEXT = 4'h8
	} link_state_e;

	typedef logic [7:0] byte_t;

	// Converter results; index 0 is local, 1 to 7 are remote
	typedef struct packed {
		byte_t [7:0] temp;
		byte_t [7:0] ot_limit;
		byte_t [7:0] hi_limit;
		byte_t lo_limit;
	} meas_s;

	// One-cycle events from the link sequencer to the registers
	typedef struct packed {
		logic cmd_we;
		logic data_we;
		logic rd_done;
		logic ara_done;
		byte_t data;
	} bus_evt_s;

	// Channel order to warning mask/status layout
	function automatic byte_t warn_order(input byte_t c);
		warn_order = {c[7], c[0], c[6:1]};
	endfunction

	// Channel order to overtemperature mask/status layout
	function automatic byte_t ot_order(input byte_t c);
		ot_order = {c[0], c[7:1]};
	endfunction
endpackage

// [bit_sync.sv]
// Two-stage synchroniser for pins from outside the system clock domain.
// Assumes idle-high open-drain lines, so both stages reset to one.
`timescale 1ns/100ps
module bit_sync #(
	parameter int W = 2
) (
	input wire logic clk_sys, // System clock
	input wire logic rst, // Asynchronous reset
	input wire logic [W-1:0] d, // Raw pin levels
	output logic [W-1:0] q // Synchronised levels
);
	logic [W-1:0] meta; // First stage, read only by q

	// Plain shift; no logic may look at meta
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			meta <= '1;
			q <= '1;
		end else begin
			meta <= d;
			q <= meta;
		end
	end
endmodule

// [ot_channel.sv]
// One overtemperature flag with hysteresis, updated per conversion.
// Assumes temperature and limit share one encoding in either range.
`timescale 1ns/100ps
module ot_channel
	import temp_alarm_pkg::*;
(
	input wire logic clk_sys, // System clock
	input wire logic rst, // Asynchronous reset
	input wire logic clr, // Soft reset
	input wire logic upd, // End of a conversion
	input wire logic [7:0] temp, // Measured temperature
	input wire logic [7:0] limit, // Overtemperature threshold
	output logic flag // Channel overtemperature
);
	logic next_flag;

	// Set above limit, hold until below limit minus hysteresis
	always_comb begin
		next_flag = flag;
		if (clr) begin
			next_flag = 1'b0;
		end else if (upd) begin
			if (temp > limit) begin
				next_flag = 1'b1;
			end else if (({1'b0, temp} + OT_HYST) < {1'b0, limit}) begin
				next_flag = 1'b0;
			end
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			flag <= 1'b0;
		end else begin
			flag <= next_flag;
		end
	end
endmodule

// [temp_alarm_ctrl.sv]
// Alarm outputs, register pointer and setup registers of the monitor.
// Assumes conv_done and meas come from the converter on clk_sys, and
// the two-wire pins are asynchronous and open-drain.
//
// Summary of operation
// - Pending device answers with its own address
// - Arbitration loser stops, keeps warning asserted
// - Alert response clears warning; reasserts if persisting
// - Overtemperature when temperature exceeds channel threshold
// - Overtemperature holds until below threshold minus 4
// - Eight-bit pointer selects register, resets zero
// - Setup bit 7 stops conversions: standby
// - Setup bit 6 restores power-on values, self-clears
// - Setup bit 5 set disables bus timeout
// - Setup bit 1 selects extended range
// - Warning mask bit suppresses its channel
// - Overtemperature mask bit suppresses its channel
// - Warning on high limit exceeded or low
// - Status read clears warning; reasserts if persisting
`timescale 1ns/100ps
module temp_alarm_ctrl
	import temp_alarm_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEF,
	parameter int TIMEOUT_CYCLES = TIMEOUT_CYC
) (
	input wire logic clk_sys, // System clock, 40 MHz
	input wire logic rst, // Asynchronous reset, active high
	input wire logic scl_in, // Serial clock pin level
	input wire logic sda_in, // Serial data pin level
	output logic sda_out, // Serial data drive level, always low
	output logic sda_oe, // Pull serial data low
	output logic alert_oe, // Pull warning line low
	output logic overt_oe, // Pull overtemperature line low
	input wire logic conv_done, // End of a conversion round
	input wire meas_s meas, // Temperatures and limits
	output logic conv_enable, // Converter may run
	output logic wide_range_enable, // Extended data encoding
	output logic soft_reset // Restore power-on values elsewhere
);
	localparam logic [19:0] TMO_LAST = 20'(TIMEOUT_CYCLES - 1);

	// Link sampling
	logic scl_s, sda_s, scl_d, sda_d;
	logic scl_rise, scl_fall, start_cond, stop_cond;
	// Link sequencer
	link_state_e state, next_state;
	logic [3:0] cnt, next_cnt; // Bit count within a byte
	byte_t shreg, next_shreg; // Receive and transmit shifter
	logic ara, next_ara; // Answering an alert response
	logic rd_dir, next_rd_dir; // Addressed for read
	logic next_sda_oe;
	logic [19:0] tmo, next_tmo; // Clock-low time
	logic tmo_hit;
	byte_t rx_byte, tx_src, rd_data;
	bus_evt_s evt;
	// Registers
	byte_t ptr, next_ptr;
	byte_t setup, next_setup;
	byte_t warn_mask, next_warn_mask;
	byte_t ot_mask, next_ot_mask;
	byte_t high_stat, next_high_stat;
	byte_t low_stat, next_low_stat;
	logic next_alert, next_overt, next_soft;
	// Alarm inputs
	logic conv; // Conversion accepted, not in standby
	byte_t hi_c, lo_c, ot_chan, ot_stat, new_high, new_low;
	logic alert_set, rd_high, rd_low;

	// Pins cross into clk_sys before anything reads them
	bit_sync #(.W(2)) u_sync (
		.clk_sys(clk_sys),
		.rst(rst),
		.d({scl_in, sda_in}),
		.q({scl_s, sda_s})
	);

	// Previous synchronised levels for edge detection
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			scl_d <= 1'b1;
			sda_d <= 1'b1;
		end else begin
			scl_d <= scl_s;
			sda_d <= sda_s;
		end
	end

	assign scl_rise = scl_s & ~scl_d;
	assign scl_fall = ~scl_s & scl_d;
	assign start_cond = scl_s & scl_d & sda_d & ~sda_s;
	assign stop_cond = scl_s & scl_d & ~sda_d & sda_s;
	assign rx_byte = {shreg[6:0], sda_s};
	// An alert response sends the own address, else the pointed register
	assign tx_src = ara ? {DEV_ADDR, 1'b0} : rd_data;
	assign tmo_hit = ~setup[BIT_NO_TIMEOUT] & (tmo == TMO_LAST);

	// Readback; unlisted indices belong to other blocks and read zero
	always_comb begin
		case (ptr)
			REG_SETUP: rd_data = setup;
			REG_WARN_MASK: rd_data = warn_mask;
			REG_OT_MASK: rd_data = ot_mask;
			REG_HIGH_STAT: rd_data = high_stat;
			REG_OT_STAT: rd_data = ot_stat;
			REG_LOW_STAT: rd_data = low_stat;
			default: rd_data = 8'h00;
		endcase
	end

	// Link sequencer: bits taken on clock rise, driven after clock fall
	always_comb begin
		next_state = state;
		next_cnt = cnt;
		next_shreg = shreg;
		next_ara = ara;
		next_rd_dir = rd_dir;
		next_sda_oe = sda_oe;
		evt = '0;
		evt.data = rx_byte;
		// Timer runs only while a frame holds the clock low
		if (scl_s || state == ST_IDLE) begin
			next_tmo = '0;
		end else if (tmo != TMO_LAST) begin
			next_tmo = tmo + 20'h00001;
		end else begin
			next_tmo = tmo;
		end
		if (start_cond) begin
			next_state = ST_ADDR;
			next_cnt = 4'h0;
			next_sda_oe = 1'b0;
		end else if (stop_cond || tmo_hit) begin
			// Timeout frees a line held by a stalled host
			next_state = ST_IDLE;
			next_sda_oe = 1'b0;
		end else begin
			case (state)
				ST_ADDR, ST_CMD, ST_WDATA: begin
					if (scl_rise) begin
						next_shreg = rx_byte;
						next_cnt = cnt + 4'h1;
						if (cnt == 4'h7) begin
							next_cnt = 4'h0;
							next_state = ST_RX_ACK;
							if (state == ST_ADDR) begin
								next_state = ST_ADDR_ACK;
								next_ara = 1'b0;
								next_rd_dir = rx_byte[0];
								if (rx_byte == ARA_BYTE && alert_oe) begin
									next_ara = 1'b1;
								end else if (rx_byte[7:1] != DEV_ADDR) begin
									next_state = ST_IDLE; // Not ours
								end
							end else if (state == ST_CMD) begin
								evt.cmd_we = 1'b1;
							end else begin
								evt.data_we = 1'b1;
							end
						end
					end
				end
				ST_ADDR_ACK, ST_RX_ACK: begin
					if (scl_fall && !sda_oe) begin
						next_sda_oe = 1'b1; // Acknowledge
					end else if (scl_fall) begin
						next_sda_oe = 1'b0;
						if (state == ST_ADDR_ACK && rd_dir) begin
							next_state = ST_TX;
							next_shreg = tx_src;
							next_sda_oe = ~tx_src[7];
						end else if (state == ST_ADDR_ACK) begin
							next_state = ST_CMD;
						end else begin
							next_state = ST_WDATA; // Further bytes rewrite
						end
					end
				end
				ST_TX: begin
					if (scl_rise) begin
						if (ara && shreg[7] && !sda_s) begin
							next_state = ST_IDLE; // Lost, no ack
						end else begin
							next_cnt = cnt + 4'h1;
							if (cnt == 4'h7) begin
								evt.rd_done = ~ara;
								evt.ara_done = ara;
							end
						end
					end else if (scl_fall && cnt == 4'h8) begin
						next_sda_oe = 1'b0; // Host acknowledges
						next_state = ST_TX_ACK;
						next_cnt = 4'h0;
					end else if (scl_fall && cnt != 4'h0) begin
						next_shreg = {shreg[6:0], 1'b0};
						next_sda_oe = ~shreg[6];
					end
				end
				ST_TX_ACK: begin
					if (scl_rise) begin
						next_state = sda_s ? ST_IDLE : ST_TX_NEXT;
					end
				end
				ST_TX_NEXT: begin
					if (scl_fall) begin
						next_state = ST_TX;
						next_shreg = tx_src;
						next_sda_oe = ~tx_src[7];
					end
				end
				default: begin
					next_state = ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state <= ST_IDLE;
			cnt <= 4'h0;
			shreg <= 8'h00;
			ara <= 1'b0;
			rd_dir <= 1'b0;
			sda_oe <= 1'b0;
			sda_out <= 1'b0;
			tmo <= 20'h00000;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			shreg <= next_shreg;
			ara <= next_ara;
			rd_dir <= next_rd_dir;
			sda_oe <= next_sda_oe;
			sda_out <= 1'b0;
			tmo <= next_tmo;
		end
	end

	// Standby drops conversion results as well as stopping the converter
	assign conv = conv_done & ~setup[BIT_STANDBY];

	// Per-channel limit compares; both encodings order the same way
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			hi_c[i] = meas.temp[i] > meas.hi_limit[i];
			lo_c[i] = meas.temp[i] < meas.lo_limit;
		end
	end

	// One hysteresis flag per channel
	for (genvar g = 0; g < 8; g++) begin : g_ot
		ot_channel u_ot (
			.clk_sys(clk_sys),
			.rst(rst),
			.clr(soft_reset),
			.upd(conv),
			.temp(meas.temp[g]),
			.limit(meas.ot_limit[g]),
			.flag(ot_chan[g])
		);
	end

	assign ot_stat = ot_order(ot_chan);

	// Register file and alarm latches; a new event beats a status read or alert response clear, soft reset beats all but the overtemperature pin
	always_comb begin
		new_high = conv ? warn_order(hi_c) : 8'h00;
		new_low = conv ? warn_order(lo_c) : 8'h00;
		alert_set = |((new_high | new_low) & ~warn_mask);
		rd_high = evt.rd_done && ptr == REG_HIGH_STAT;
		rd_low = evt.rd_done && ptr == REG_LOW_STAT;
		next_ptr = evt.cmd_we ? evt.data : ptr;
		next_setup = setup;
		next_warn_mask = warn_mask;
		next_ot_mask = ot_mask;
		next_soft = 1'b0;
		if (evt.data_we) begin
			case (ptr)
				REG_SETUP: begin
					// Reserved bits are not stored
					next_setup = evt.data & SETUP_KEEP;
					next_soft = evt.data[BIT_SOFT_RST];
				end
				REG_WARN_MASK: next_warn_mask = evt.data;
				REG_OT_MASK: next_ot_mask = evt.data;
				default: next_soft = 1'b0;
			endcase
		end
		next_high_stat = new_high | (high_stat & ~{8{rd_high}});
		next_low_stat = new_low | (low_stat & ~{8{rd_low}});
		next_alert = alert_set |
			(alert_oe & ~(evt.ara_done | rd_high | rd_low));
		next_overt = |(ot_stat & ~ot_mask);
		if (soft_reset) begin
			// Whole map back to power-on values
			next_ptr = PTR_RST;
			next_setup = SETUP_RST;
			next_warn_mask = MASK_RST;
			next_ot_mask = MASK_RST;
			next_high_stat = STAT_RST;
			next_low_stat = STAT_RST;
			next_alert = 1'b0;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ptr <= PTR_RST;
			setup <= SETUP_RST;
			warn_mask <= MASK_RST;
			ot_mask <= MASK_RST;
			high_stat <= STAT_RST;
			low_stat <= STAT_RST;
			alert_oe <= 1'b0;
			overt_oe <= 1'b0;
			soft_reset <= 1'b0;
			conv_enable <= 1'b1;
			wide_range_enable <= 1'b0;
		end else begin
			ptr <= next_ptr;
			setup <= next_setup;
			warn_mask <= next_warn_mask;
			ot_mask <= next_ot_mask;
			high_stat <= next_high_stat;
			low_stat <= next_low_stat;
			alert_oe <= next_alert;
			overt_oe <= next_overt;
			soft_reset <= next_soft;
			conv_enable <= ~next_setup[BIT_STANDBY];
			wide_range_enable <= next_setup[BIT_WIDE];
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	sequence s_setup_wr;
		evt.data_we && ptr == REG_SETUP;
	endsequence
	sequence s_back_to_por;
		setup == SETUP_RST && ptr == PTR_RST && !soft_reset;
	endsequence

	property p_ara_pending;
		(state == ST_ADDR_ACK && ara) |-> alert_oe;
	endproperty
	a_ara_pending: assert property (p_ara_pending)
		else $error("alert response answered with nothing pending");
	property p_arb_lost;
		(state == ST_TX && ara && scl_rise && shreg[7] && !sda_s)
			|=> (state == ST_IDLE && !sda_oe && alert_oe);
	endproperty
	a_arb_lost: assert property (p_arb_lost)
		else $error("losing device kept driving or dropped warning");
	property p_ara_clear;
		(evt.ara_done && !alert_set && !soft_reset) |=> !alert_oe;
	endproperty
	a_ara_clear: assert property (p_ara_clear)
		else $error("warning not cleared by alert response");
	property p_warn_raise;
		(conv && |(warn_order(hi_c) & ~warn_mask) && !soft_reset)
			|=> alert_oe;
	endproperty
	a_warn_raise: assert property (p_warn_raise)
		else $error("warning missed an unmasked high event");
	property p_stat_read;
		(rd_high && !alert_set && !soft_reset) |=> !alert_oe;
	endproperty
	a_stat_read: assert property (p_stat_read)
		else $error("status read did not clear warning");
	property p_ot_hold;
		(ot_chan[0] && !soft_reset && !(9'(meas.temp[0]) + OT_HYST
			< 9'(meas.ot_limit[0]))) |=> ot_chan[0];
	endproperty
	a_ot_hold: assert property (p_ot_hold)
		else $error("overtemperature released inside hysteresis");
	property p_ot_set;
		(conv && meas.temp[0] > meas.ot_limit[0] && !soft_reset
			&& !ot_mask[7]) |=> ##1 overt_oe;
	endproperty
	a_ot_set: assert property (p_ot_set)
		else $error("overtemperature output missed local event");
	property p_ptr_load;
		evt.cmd_we && !soft_reset |=> ptr == $past(evt.data);
	endproperty
	a_ptr_load: assert property (p_ptr_load)
		else $error("pointer did not take command byte");
	property p_standby;
		(setup[BIT_STANDBY] && !soft_reset) |=> $stable(ot_chan);
	endproperty
	a_standby: assert property (p_standby)
		else $error("flags changed while in standby");
	property p_soft;
		(s_setup_wr ##0 evt.data[BIT_SOFT_RST]) |=> soft_reset
			##1 s_back_to_por;
	endproperty
	a_soft: assert property (p_soft)
		else $error("soft reset did not restore power-on values");
	property p_timeout;
		tmo_hit && !start_cond |=> state == ST_IDLE && !sda_oe;
	endproperty
	a_timeout: assert property (p_timeout)
		else $error("bus timeout did not free the line");
	property p_range;
		s_setup_wr |=>
			wide_range_enable == $past(evt.data[BIT_WIDE]);
	endproperty
	a_range: assert property (p_range)
		else $error("range select not following setup bit 1");
	property p_warn_mask;
		(!alert_oe && (!conv || ((warn_order(hi_c) | warn_order(lo_c))
			& ~warn_mask) == 8'h00)) |=> !alert_oe;
	endproperty
	a_warn_mask: assert property (p_warn_mask)
		else $error("masked or absent events asserted warning");
	// Any flag set but masked must leave the pin released
	property p_ot_mask;
		((ot_stat & ~ot_mask) == 8'h00) |=> !overt_oe;
	endproperty
	a_ot_mask: assert property (p_ot_mask)
		else $error("masked overtemperature asserted");
endmodule

// [smb_host.sv]
// Behavioural two-wire host that drives the monitor's serial port.
// Assumes a pull-up on both lines; the bench resolves the data wire.
`timescale 1ns/100ps
module smb_host (
	input wire logic clk_sys, // System clock, paces the bit timing
	output logic scl, // Serial clock, low only inside frames
	output logic sda_pull, // High while the host pulls data low
	input wire logic sda // Resolved data line level
);
	// Idle bus: clock high, data released
	initial begin
		scl = 1'b1;
		sda_pull = 1'b0;
	end

	// Wait a number of system clock edges
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
	endtask

	// Start or repeated start; data falls while the clock is high
	task automatic start_c();
		sda_pull <= 1'b0;
		tick(2);
		scl <= 1'b1;
		tick(2);
		sda_pull <= 1'b1;
		tick(2);
		scl <= 1'b0;
		tick(2);
	endtask

	// Stop; data rises while the clock is high, then the bus rests
	task automatic stop_c();
		sda_pull <= 1'b1;
		tick(2);
		scl <= 1'b1;
		tick(2);
		sda_pull <= 1'b0;
		tick(4);
	endtask

	// One bit, 200 ns; data changes only while the clock is low
	task automatic xbit(input logic v, output logic s);
		sda_pull <= ~v;
		tick(2);
		scl <= 1'b1;
		tick(2);
		s = sda;
		tick(2);
		scl <= 1'b0;
		tick(2);
	endtask

	// Eight bits MSB first, then the acknowledge bit
	task automatic xbyte(input logic [7:0] tx, input logic ack_tx,
		output logic [7:0] rx, output logic ack_rx);
		logic b;
		for (int i = 7; i >= 0; i--) begin
			xbit(tx[i], b);
			rx[i] = b;
		end
		xbit(ack_tx, ack_rx);
	endtask
endmodule

// [tb.sv]
// Self-checking bench for the alarm controller through its serial port.
// Assumes the converter is modelled here by a conv_done pulse and meas.
`timescale 1ns/100ps
module tb;
	import temp_alarm_pkg::*;
	logic clk_sys = 1'b0; // 40 MHz
	logic rst = 1'b1; // Asynchronous reset
	logic conv_done = 1'b0; // Conversion round ends
	meas_s meas; // Converter results
	logic sda_out, sda_oe, alert_oe, overt_oe; // Device outputs
	logic conv_enable, wide_range_enable, soft_reset; // Device outputs
	logic scl, sda_pull; // Host drive
	wire logic sda; // Resolved data wire with pull-up
	int miscompares = 0;
	int checks_done = 0;
	int cyc = 0; // Cycles since start, for the hang limit
	logic sr_seen = 1'b0; // Soft reset pulse was observed
	logic [7:0] ot_t [4] = '{8'h51, 8'h4D, 8'h4B, 8'h50}; // Trial temps
	logic [7:0] ot_e [4] = '{8'h01, 8'h01, 8'h00, 8'h00}; // Expected pin

	// Wired-AND of both parties; released data reads high
	assign sda = (sda_oe ? sda_out : 1'b1) & ~sda_pull;

	always #12.5 clk_sys = ~clk_sys;

	temp_alarm_ctrl #(.DEV_ADDR(DEV_ADDR_DEF), .TIMEOUT_CYCLES(200))
		temp_alarm_ctrl_i (.clk_sys(clk_sys), .rst(rst), .scl_in(scl),
		.sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
		.alert_oe(alert_oe), .overt_oe(overt_oe), .conv_done(conv_done),
		.meas(meas), .conv_enable(conv_enable),
		.wide_range_enable(wide_range_enable), .soft_reset(soft_reset));

	smb_host smb_host_i (.clk_sys(clk_sys), .scl(scl),
		.sda_pull(sda_pull), .sda(sda));

	// Pulse is one cycle wide, so catch it in a sticky flag
	always @(posedge clk_sys) begin
		if (soft_reset === 1'b1) begin
			sr_seen <= 1'b1;
		end
	end

	// Hang limit, well above the few thousand cycles the run needs
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			miscompares++;
			report_and_stop();
		end
	end

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED t=%0t seen %h expected %h", $time, seen,
				exp);
		end
	endtask

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// Write pointer, optionally followed by one data byte
	task automatic wr(input logic [7:0] r, input logic [7:0] v,
		input logic with_data);
		logic [7:0] d;
		logic a0, a1, a2;
		a2 = 1'b0;
		smb_host_i.start_c();
		smb_host_i.xbyte({DEV_ADDR_DEF, 1'b0}, 1'b1, d, a0);
		smb_host_i.xbyte(r, 1'b1, d, a1);
		if (with_data) begin
			smb_host_i.xbyte(v, 1'b1, d, a2);
		end
		smb_host_i.stop_c();
		check({7'h00, a0 | a1 | a2}, 8'h00);
	endtask

	// Address byte, then one byte clocked back; tx 1s let the device drive
	task automatic rx(input logic [7:0] ab, input logic [7:0] tx,
		input logic nak, input logic [7:0] exp);
		logic [7:0] d;
		logic a;
		smb_host_i.start_c();
		smb_host_i.xbyte(ab, 1'b1, d, a);
		check({7'h00, a}, {7'h00, nak});
		if (a === 1'b0) begin
			smb_host_i.xbyte(tx, 1'b1, d, a);
			check(d, exp);
		end
		smb_host_i.stop_c();
	endtask

	// Register read through the pointer
	task automatic rdc(input logic [7:0] r, input logic [7:0] exp);
		wr(r, 8'h00, 1'b0);
		rx({DEV_ADDR_DEF, 1'b1}, 8'hFF, 1'b0, exp);
	endtask

	// Address, then the clock held low past the bench timeout of 200
	task automatic to_frame(input logic nak);
		logic [7:0] d;
		logic a;
		smb_host_i.start_c();
		smb_host_i.xbyte({DEV_ADDR_DEF, 1'b0}, 1'b1, d, a);
		check({7'h00, a}, 8'h00);
		smb_host_i.tick(250);
		smb_host_i.xbyte(REG_WARN_MASK, 1'b1, d, a);
		check({7'h00, a}, {7'h00, nak});
		smb_host_i.stop_c();
	endtask

	// One conversion round; both alarm pins settle within three edges
	task automatic conv();
		@(posedge clk_sys);
		conv_done <= 1'b1;
		@(posedge clk_sys);
		conv_done <= 1'b0;
		smb_host_i.tick(3);
	endtask

	initial begin
		for (int i = 0; i < 8; i++) begin
			meas.temp[i] = 8'h20;
			meas.ot_limit[i] = 8'h7F;
			meas.hi_limit[i] = 8'h7F;
		end
		meas.lo_limit = 8'h00;
		smb_host_i.tick(6);
		rst <= 1'b0;
		smb_host_i.tick(4);
		// Power-on state
		rx({DEV_ADDR_DEF, 1'b1}, 8'hFF, 1'b0, PTR_RST);
		rdc(REG_SETUP, SETUP_RST);
		rdc(REG_WARN_MASK, MASK_RST);
		rdc(REG_OT_MASK, MASK_RST);
		check({7'h00, conv_enable}, 8'h01);
		check({7'h00, wide_range_enable}, 8'h00);
		// Foreign address and alert poll with nothing pending: no ack
		rx({7'h4D, 1'b1}, 8'hFF, 1'b1, 8'h00);
		rx(ARA_BYTE, 8'hFF, 1'b1, 8'h00);
		// Standby, no timeout, wide range; reserved bits kept zero
		wr(REG_SETUP, 8'hA2, 1'b1);
		rdc(REG_SETUP, 8'hA2);
		check({7'h00, conv_enable}, 8'h00);
		check({7'h00, wide_range_enable}, 8'h01);
		meas.hi_limit[3] <= 8'h50;
		meas.temp[3] <= 8'h60;
		conv();
		check({7'h00, alert_oe}, 8'h00);
		wr(REG_SETUP, 8'h00, 1'b1);
		check({7'h00, conv_enable}, 8'h01);
		// High event on channel 3, cleared by a status read
		conv();
		check({7'h00, alert_oe}, 8'h01);
		rdc(REG_HIGH_STAT, 8'h04);
		check({7'h00, alert_oe}, 8'h00);
		conv();
		check({7'h00, alert_oe}, 8'h01);
		// Alert response returns our address and clears the latch
		rx(ARA_BYTE, 8'hFF, 1'b0, {DEV_ADDR_DEF, 1'b0});
		check({7'h00, alert_oe}, 8'h00);
		conv();
		check({7'h00, alert_oe}, 8'h01);
		// A lower address on the wire wins; ours stays pending
		rx(ARA_BYTE, 8'h10, 1'b0, 8'h10);
		check({7'h00, alert_oe}, 8'h01);
		// Masking channel 3 keeps the warning line quiet
		wr(REG_WARN_MASK, 8'h04, 1'b1);
		rdc(REG_HIGH_STAT, 8'h04);
		conv();
		check({7'h00, alert_oe}, 8'h00);
		meas.temp[3] <= 8'h20;
		// Low event on channel 5, cleared by reading the low status
		meas.lo_limit <= 8'h10;
		meas.temp[5] <= 8'h08;
		conv();
		check({7'h00, alert_oe}, 8'h01);
		rdc(REG_LOW_STAT, 8'h10);
		check({7'h00, alert_oe}, 8'h00);
		meas.temp[5] <= 8'h20;
		// Local overtemperature: threshold, then hysteresis of four
		meas.ot_limit[0] <= 8'h50;
		for (int i = 0; i < 4; i++) begin
			meas.temp[0] <= ot_t[i];
			conv();
			check({7'h00, overt_oe}, ot_e[i]);
		end
		meas.temp[0] <= 8'h60;
		wr(REG_OT_MASK, 8'h80, 1'b1);
		conv();
		check({7'h00, overt_oe}, 8'h00);
		// The flag stands in the status even while its pin is masked
		rdc(REG_OT_STAT, 8'h80);
		wr(REG_OT_MASK, 8'h01, 1'b1);
		conv();
		check({7'h00, overt_oe}, 8'h01);
		// Soft reset restores power-on values and clears itself
		wr(REG_SETUP, 8'h40, 1'b1);
		check({7'h00, sr_seen}, 8'h01);
		check({7'h00, overt_oe}, 8'h00);
		rdc(REG_OT_MASK, MASK_RST);
		rdc(REG_SETUP, SETUP_RST);
		// Clock held low inside a frame: timeout drops it unless disabled
		to_frame(1'b1);
		wr(REG_SETUP, 8'h20, 1'b1);
		to_frame(1'b0);
		report_and_stop();
	end
endmodule
